/* srdc_pkg.sv */
// Constants, field layout and types for the sync gating and output config bank
// How it works
// - Global gate: 00 passes all, 01 passes first only, 10 blocks all.
// - Global gate also feeds the test pattern generator's sync.
// - Bits 7-6 gate sync to the serial output block; reset is pass-all.
// - Bits 5-4 gate sync to the decimation filters, same encoding.
// - Bits 3-2 gate sync to the oscillators, same encoding.
// - Bits 1-0 gate sync to the oscillator timer, same encoding.
// - Stamp field 3 puts the sync input on the sample low bit.
// - Overrange-on-low-bit beats the sync stamp when both are on.
// - Gain field 2 forces unity gain in either mode.
// - Bit 2 picks real (0) or complex (1) decimation for all filters.
// - Bit 1 picks 14/16-bit (0) or 32-bit (1) output samples.
// - Bit 0 picks two's complement (0) or offset binary (1).
// - Filters 0,2: 00 is A, 01 is B; filters 1,3 swap.
// - Source 10 feeds (A plus B) halved.
// - Source 11 feeds (A minus B) halved.
// - A 0-to-1 on an oscillator load bit loads that oscillator.
// - Mode bit 0 is phase continuous, 1 is phase coherent.
package srdc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SMP_W = 14;
  localparam int OUT_W = 16;
  localparam int NUM_GATES = 5;
  localparam int NUM_FILT = 4;
  localparam int NUM_OSC = 4;

  localparam logic [ADDR_W-1:0] OFS_GLOBAL_GATE = 16'h0160;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_GATES = 16'h0161;
  localparam logic [ADDR_W-1:0] OFS_OUT_CFG = 16'h0162;
  localparam logic [ADDR_W-1:0] OFS_SRC_SEL = 16'h0163;
  localparam logic [ADDR_W-1:0] OFS_OSC_MODE = 16'h0164;

  localparam logic [DATA_W-1:0] RST_GLOBAL_GATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_BLOCK_GATES = 8'h00;
  localparam logic [DATA_W-1:0] RST_OUT_CFG = 8'h00;
  localparam logic [DATA_W-1:0] RST_SRC_SEL = 8'h00;
  localparam logic [DATA_W-1:0] RST_OSC_MODE = 8'h00;

  // Writable masks; reserved positions are dropped
  localparam logic [DATA_W-1:0] MASK_GLOBAL_GATE = 8'h03;
  localparam logic [DATA_W-1:0] MASK_BLOCK_GATES = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_OUT_CFG = 8'hDF;
  localparam logic [DATA_W-1:0] MASK_SRC_SEL = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_OSC_MODE = 8'hF9;

  // Field positions
  localparam int GG_LSB = 0;
  localparam int BG_SERIAL_LSB = 6;
  localparam int BG_FILTER_LSB = 4;
  localparam int BG_OSC_LSB = 2;
  localparam int BG_TIMER_LSB = 0;
  localparam int OC_STAMP_LSB = 6;
  localparam int OC_GAIN_LSB = 3;
  localparam int OC_COMPLEX_BIT = 2;
  localparam int OC_WIDTH_BIT = 1;
  localparam int OC_FORMAT_BIT = 0;
  localparam int OM_LOAD_LSB = 4;
  localparam int OM_NEG_IMAGE_BIT = 3;
  localparam int OM_MODE_BIT = 0;

  localparam logic [1:0] STAMP_ON = 2'h3;
  localparam logic [1:0] GAIN_DEFAULT = 2'h0;
  localparam logic [1:0] GAIN_FORCE_6DB = 2'h3;
  localparam logic [1:0] GAIN_FORCE_UNITY = 2'h2;

  // Gate index order
  localparam int GI_GLOBAL = 0;
  localparam int GI_SERIAL = 1;
  localparam int GI_FILTER = 2;
  localparam int GI_OSC = 3;
  localparam int GI_TIMER = 4;

  typedef enum logic [1:0] {
    GATE_PASS_ALL = 2'h0,
    GATE_PASS_FIRST = 2'h1,
    GATE_BLOCK_ALL = 2'h2,
    GATE_ISSUE = 2'h3
  } srdc_gate_e;

  typedef enum logic [1:0] {
    SRC_OWN = 2'h0,
    SRC_OTHER = 2'h1,
    SRC_SUM = 2'h2,
    SRC_DIFF = 2'h3
  } srdc_src_e;
endpackage

/* srdc_props.sv */
// Port-level checks on the sync gating and output config bank
`timescale 1ns/1ps
module srdc_props (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Reset
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic sync_pattern, // Pattern sync
  input wire logic sysref_in, // Sync input
  input wire logic gain_6db, // Gain flag
  input wire logic complex_decimation_enable, // Complex
  input wire logic output_width_select, // Width
  input wire logic offset_binary, // Format
  input wire logic [3:0] osc_load, // Loads
  input wire logic negative_image_select, // Image
  input wire logic osc_coherent_mode // Mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Write decodes; a pattern sync needs an input pulse or a fresh issue write
  wire w_cfg = reg_wr && reg_addr == srdc_pkg::OFS_OUT_CFG;
  wire w_osc = reg_wr && reg_addr == srdc_pkg::OFS_OSC_MODE;
  wire w_gg = reg_wr && reg_addr == srdc_pkg::OFS_GLOBAL_GATE;
  cplx_level_a: assert property (w_cfg |=> complex_decimation_enable == $past(reg_wdata[2]))
    else $error("complex select not taken");
  width_level_a: assert property (w_cfg |=> output_width_select == $past(reg_wdata[1]))
    else $error("width select not taken");
  format_level_a: assert property (w_cfg |=> offset_binary == $past(reg_wdata[0]))
    else $error("format select not taken");
  osc_mode_a: assert property (w_osc |=> osc_coherent_mode == $past(reg_wdata[0]))
    else $error("oscillator mode not taken");
  gain_force_a: assert property (w_cfg && reg_wdata[4:3] == 2'h3 ##1 !w_cfg |=> gain_6db)
    else $error("forced gain missing");
  gain_unity_a: assert property (w_cfg && reg_wdata[4:3] == 2'h2 ##1 !w_cfg |=> !gain_6db)
    else $error("unity gain missing");
  load_cause_a: assert property (osc_load != 4'h0 |-> $past(w_osc) || $past(w_osc, 2))
    else $error("load pulse without write");
  load_single_a: assert property (osc_load[0] |=> !osc_load[0])
    else $error("load pulse too long");
  sync_cause_a: assert property (sync_pattern |-> $past(sysref_in) || $past(w_gg, 2))
    else $error("pattern sync without cause");
  unmapped_read_a: assert property (reg_rd && reg_addr > 16'h0164 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind srdc_top srdc_props props_u (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sync_pattern(sync_pattern), .sysref_in(sysref_in), .gain_6db(gain_6db),
  .complex_decimation_enable(complex_decimation_enable), .offset_binary(offset_binary),
  .output_width_select(output_width_select), .osc_load(osc_load),
  .negative_image_select(negative_image_select), .osc_coherent_mode(osc_coherent_mode));

/* srdc_tb.sv */
// Self-checking bench for the sync gating and output config bank
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares += 1; if ((s) !== (e)) begin n_fail += 1; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module testbench;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, sysref_in = 0;
  logic overrange_in = 0, overrange_on_low_bit = 0;
  logic [15:0] reg_addr = 0, sample_in = 0, sample_out, s;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [13:0] ch_a = 0, ch_b = 0;
  logic sync_pattern, sync_serial, sync_filter, sync_osc, sync_timer, gain_6db;
  logic complex_decimation_enable, output_width_select, offset_binary;
  logic negative_image_select, osc_coherent_mode;
  logic [55:0] filter_in;
  logic [3:0] osc_load;
  logic [31:0] rng = 32'hd1ad_7d2f;
  logic [7:0] mdl[5] = '{default: 8'h00}; // Model register contents
  localparam logic [7:0] MSK[5] = '{8'h03, 8'hff, 8'hdf, 8'hff, 8'hf9};
  int n_fail = 0, compares = 0, cyc = 0, n = 0;
  int cnt[5];
  int gexp[3] = '{3, 1, 0};
  logic [7:0] gcfg[5] = '{8'h00, 8'h04, 8'h18, 8'h14, 8'h0c};
  logic gexpg[5] = '{0, 1, 1, 0, 1};
  wire [4:0] so = {sync_timer, sync_osc, sync_filter, sync_serial, sync_pattern};
  // Level outputs gathered in register bit order for one compare
  wire [4:0] lv = {complex_decimation_enable, output_width_select, offset_binary,
    negative_image_select, osc_coherent_mode};
  srdc_top dut_u (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sysref_in(sysref_in),
    .ch_a(ch_a), .ch_b(ch_b), .sample_in(sample_in), .overrange_in(overrange_in),
    .overrange_on_low_bit(overrange_on_low_bit), .sync_pattern(sync_pattern),
    .sync_serial(sync_serial), .sync_filter(sync_filter), .sync_osc(sync_osc),
    .sync_timer(sync_timer), .filter_in(filter_in), .sample_out(sample_out),
    .gain_6db(gain_6db), .complex_decimation_enable(complex_decimation_enable),
    .output_width_select(output_width_select), .offset_binary(offset_binary),
    .osc_load(osc_load), .negative_image_select(negative_image_select),
    .osc_coherent_mode(osc_coherent_mode));
  initial forever #2 sys_clk = ~sys_clk;
  // Hang guard, well past the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail += 1;
      summarize();
    end
  end
  function automatic logic [31:0] nxt();
    rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
    return rng;
  endfunction
  // Filter source model: halved sum or difference truncates toward minus infinity
  function automatic logic [13:0] src(int f, logic [1:0] c, logic [13:0] a, logic [13:0] b);
    logic signed [14:0] t;
    t = c[0] ? $signed(a) - $signed(b) : $signed(a) + $signed(b);
    return c[1] ? t[14:1] : ((c[0] ^ f[0]) ? b : a);
  endfunction
  task automatic wr(input int i, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1;
    reg_addr = srdc_pkg::OFS_GLOBAL_GATE + 16'(i);
    // Software side keeps reserved positions at zero
    reg_wdata = (i < 5) ? d & MSK[i] : d;
    @(negedge sys_clk);
    reg_wr = 0;
    if (i < 5) mdl[i] = d & MSK[i];
  endtask
  task automatic rd(input int i);
    @(negedge sys_clk);
    reg_rd = 1;
    reg_addr = srdc_pkg::OFS_GLOBAL_GATE + 16'(i);
    @(negedge sys_clk);
    reg_rd = 0;
    `CHK("rdata", (i < 5) ? mdl[i] : 8'h00, reg_rdata)
  endtask
  // Send n sync pulses (or none) and count each gated output over 4 cycles apiece
  task automatic run(input int k, input logic p);
    cnt = '{default: 0};
    repeat (k) begin
      sysref_in = p;
      repeat (4) begin
        @(negedge sys_clk);
        sysref_in = 0;
        for (int j = 0; j < 5; j++) cnt[j] += int'(so[j]);
      end
    end
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) reset = 0;
    for (int i = 0; i < 6; i++) rd(i);
    for (int i = 0; i < 5; i++) begin
      wr(i, nxt());
      rd(i);
    end
    `CHK("levels", {mdl[2][2:0], mdl[4][3], mdl[4][0]}, lv)
    for (int i = 0; i < 5; i++) wr(i, 8'h00);
    done("registers");
    for (int m = 0; m < 3; m++) begin
      wr(0, 8'(m));
      run(3, 1);
      `CHK("global", gexp[m], cnt[0])
      `CHK("serial", gexp[m], cnt[1])
    end
    wr(0, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(1, 8'h02 << (2 * f));
      run(2, 1);
      `CHK("blocked", 0, cnt[4 - f])
      `CHK("passed", 6, cnt[1] + cnt[2] + cnt[3] + cnt[4])
    end
    wr(1, 8'h00);
    wr(0, 8'h03);
    run(1, 0);
    `CHK("issue", 1, cnt[0])
    `CHK("issue_blk", 1, cnt[2])
    run(1, 0);
    `CHK("issue_once", 0, cnt[0])
    wr(0, 8'h00);
    done("gating");
    for (int c = 0; c < 4; c++) begin
      wr(3, {4{2'(c)}});
      ch_a = 14'(nxt());
      ch_b = 14'(nxt());
      repeat (2) @(negedge sys_clk);
      for (int f = 0; f < 4; f++) begin
        `CHK("source", src(f, 2'(c), ch_a, ch_b), filter_in[14*f +: 14])
      end
    end
    // Code 01 of the gain field behaves as the default
    for (int g = 0; g < 5; g++) begin
      wr(2, gcfg[g]);
      repeat (2) @(negedge sys_clk);
      `CHK("gain", gexpg[g], gain_6db)
    end
    for (int k = 0; k < 4; k++) begin
      wr(2, 8'hc0 | 8'(k[0]));
      overrange_on_low_bit = k[1];
      overrange_in = k[0];
      sysref_in = 1;
      s = 16'(nxt());
      sample_in = s;
      @(negedge sys_clk);
      sysref_in = 0;
      `CHK("sample", {s[15] ^ k[0], s[14:1], k[1] ? k[0] : 1'b1}, sample_out)
    end
    done("datapath");
    for (int r = 0; r < 2; r++) begin
      wr(4, 8'hf0);
      // The pulse already stands when the write task returns
      n = $countones(osc_load);
      repeat (2) begin
        @(negedge sys_clk);
        n += $countones(osc_load);
      end
      `CHK("loads", r ? 0 : 4, n)
    end
    done("loads");
    summarize();
  end
endmodule

/* srdc_top.sv */
// Sync gating, sample stamping, filter source mux and output config bank
`timescale 1ns/1ps
module srdc_top (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [15:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  input wire logic sysref_in, // Sync pulse input
  input wire logic [13:0] ch_a, // Channel A sample
  input wire logic [13:0] ch_b, // Channel B sample
  input wire logic [15:0] sample_in, // Output sample before formatting
  input wire logic overrange_in, // Overrange indication
  input wire logic overrange_on_low_bit, // Overrange-on-low-bit option
  output logic sync_pattern, // Sync to test pattern generator
  output logic sync_serial, // Sync to serial output block
  output logic sync_filter, // Sync to decimation filters
  output logic sync_osc, // Sync to oscillators
  output logic sync_timer, // Sync to oscillator timer
  output logic [55:0] filter_in, // Four 14-bit filter inputs, filter 0 low
  output logic [15:0] sample_out, // Formatted output sample
  output logic gain_6db, // Apply 6 dB on filter output
  output logic complex_decimation_enable, // 1 complex, 0 real
  output logic output_width_select, // 1 selects 32-bit samples
  output logic offset_binary, // 1 offset binary, 0 two's complement
  output logic [3:0] osc_load, // One-cycle load pulse per oscillator
  output logic negative_image_select, // Negative image select
  output logic osc_coherent_mode // 1 phase coherent, 0 continuous
);
  typedef struct packed {
    logic [7:0] global_gate;
    logic [7:0] block_gates;
    logic [7:0] out_cfg;
    logic [7:0] src_sel;
    logic [7:0] osc_mode;
    logic [7:0] rdata;
    logic [srdc_pkg::NUM_GATES-1:0] seen;
    logic [srdc_pkg::NUM_GATES-1:0][1:0] prev_mode;
    logic [srdc_pkg::NUM_GATES-1:0] sync;
    logic [srdc_pkg::NUM_FILT-1:0][13:0] filt;
    logic [15:0] sample;
    logic gain;
    logic [3:0] load;
  } srdc_state_s;

  srdc_state_s state_reg;
  srdc_state_s state_next;

  // Gate step: returns {pass, seen_next}
  function automatic logic [1:0] gate_step(input logic [1:0] mode, input logic [1:0] prev,
                                           input logic seen, input logic pulse);
    logic pass;
    logic seen_n;
    pass = 1'b0;
    seen_n = 1'b0;
    unique case (srdc_pkg::srdc_gate_e'(mode))
      srdc_pkg::GATE_PASS_ALL: pass = pulse;
      srdc_pkg::GATE_PASS_FIRST: begin
        pass = pulse & ~seen;
        seen_n = seen | pulse;
      end
      srdc_pkg::GATE_BLOCK_ALL: pass = 1'b0;
      srdc_pkg::GATE_ISSUE: pass = (prev != srdc_pkg::GATE_ISSUE);
    endcase
    return {pass, seen_n};
  endfunction

  // Source mux; odd filters swap the A/B meaning of codes 00 and 01
  function automatic logic [13:0] src_pick(input logic [1:0] sel, input logic swap,
                                           input logic [13:0] a, input logic [13:0] b);
    logic [14:0] sum;
    logic [14:0] dif;
    logic [13:0] res;
    sum = {a[13], a} + {b[13], b};
    dif = {a[13], a} - {b[13], b};
    res = a;
    unique case (srdc_pkg::srdc_src_e'(sel))
      srdc_pkg::SRC_OWN: res = swap ? b : a;
      srdc_pkg::SRC_OTHER: res = swap ? a : b;
      srdc_pkg::SRC_SUM: res = sum[14:1];
      srdc_pkg::SRC_DIFF: res = dif[14:1];
    endcase
    return res;
  endfunction

  logic [srdc_pkg::NUM_GATES-1:0][1:0] gate_mode;
  logic [1:0] gstep;
  logic [1:0] bstep;
  logic [1:0] gain_sel;
  logic global_pass;
  logic [15:0] smp;

  // Field views of the gate registers
  assign gate_mode[srdc_pkg::GI_GLOBAL] = state_reg.global_gate[srdc_pkg::GG_LSB +: 2];
  assign gate_mode[srdc_pkg::GI_SERIAL] = state_reg.block_gates[srdc_pkg::BG_SERIAL_LSB +: 2];
  assign gate_mode[srdc_pkg::GI_FILTER] = state_reg.block_gates[srdc_pkg::BG_FILTER_LSB +: 2];
  assign gate_mode[srdc_pkg::GI_OSC] = state_reg.block_gates[srdc_pkg::BG_OSC_LSB +: 2];
  assign gate_mode[srdc_pkg::GI_TIMER] = state_reg.block_gates[srdc_pkg::BG_TIMER_LSB +: 2];
  assign gain_sel = state_reg.out_cfg[srdc_pkg::OC_GAIN_LSB +: 2];

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;
    gstep = '0;
    bstep = '0;
    global_pass = 1'b0;
    smp = '0;
    state_next.load = '0;
    // Register writes; reserved bits are masked away
    if (reg_wr) begin
      unique case (reg_addr)
        srdc_pkg::OFS_GLOBAL_GATE:
          state_next.global_gate = reg_wdata & srdc_pkg::MASK_GLOBAL_GATE;
        srdc_pkg::OFS_BLOCK_GATES:
          state_next.block_gates = reg_wdata & srdc_pkg::MASK_BLOCK_GATES;
        srdc_pkg::OFS_OUT_CFG:
          state_next.out_cfg = reg_wdata & srdc_pkg::MASK_OUT_CFG;
        srdc_pkg::OFS_SRC_SEL:
          state_next.src_sel = reg_wdata & srdc_pkg::MASK_SRC_SEL;
        srdc_pkg::OFS_OSC_MODE:
          state_next.osc_mode = reg_wdata & srdc_pkg::MASK_OSC_MODE;
        default: ;
      endcase
    end
    // Reads answer next cycle; unmapped addresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        srdc_pkg::OFS_GLOBAL_GATE: state_next.rdata = state_reg.global_gate;
        srdc_pkg::OFS_BLOCK_GATES: state_next.rdata = state_reg.block_gates;
        srdc_pkg::OFS_OUT_CFG: state_next.rdata = state_reg.out_cfg;
        srdc_pkg::OFS_SRC_SEL: state_next.rdata = state_reg.src_sel;
        srdc_pkg::OFS_OSC_MODE: state_next.rdata = state_reg.osc_mode;
        default: state_next.rdata = '0;
      endcase
    end
    // Load pulses on rising edges of the stored load bits
    state_next.load = state_next.osc_mode[srdc_pkg::OM_LOAD_LSB +: srdc_pkg::NUM_OSC]
                    & ~state_reg.osc_mode[srdc_pkg::OM_LOAD_LSB +: srdc_pkg::NUM_OSC];
    // Global gate first; its result feeds every block gate and the pattern
    gstep = gate_step(gate_mode[srdc_pkg::GI_GLOBAL], state_reg.prev_mode[srdc_pkg::GI_GLOBAL],
                      state_reg.seen[srdc_pkg::GI_GLOBAL], sysref_in);
    global_pass = gstep[1];
    state_next.sync[srdc_pkg::GI_GLOBAL] = global_pass;
    state_next.seen[srdc_pkg::GI_GLOBAL] = gstep[0];
    // Block gates chained behind the global one
    for (int i = srdc_pkg::GI_SERIAL; i < srdc_pkg::NUM_GATES; i++) begin
      bstep = gate_step(gate_mode[i], state_reg.prev_mode[i], state_reg.seen[i], global_pass);
      state_next.sync[i] = bstep[1];
      state_next.seen[i] = bstep[0];
    end
    // Previous mode tracks the live field so issue fires once per entry
    state_next.prev_mode = gate_mode;
    // Filter source selection per filter
    for (int f = 0; f < srdc_pkg::NUM_FILT; f++) begin
      state_next.filt[f] = src_pick(state_reg.src_sel[2*f +: 2], f[0], ch_a, ch_b);
    end
    // Gain decision; code 1 behaves like the default
    unique case (gain_sel)
      srdc_pkg::GAIN_FORCE_6DB: state_next.gain = 1'b1;
      srdc_pkg::GAIN_FORCE_UNITY: state_next.gain = 1'b0;
      default: state_next.gain = state_reg.out_cfg[srdc_pkg::OC_COMPLEX_BIT];
    endcase
    // Low bit stamping, overrange has priority, then format
    smp = sample_in;
    if (overrange_on_low_bit) begin
      smp[0] = overrange_in;
    end else if (state_reg.out_cfg[srdc_pkg::OC_STAMP_LSB +: 2] == srdc_pkg::STAMP_ON) begin
      smp[0] = sysref_in;
    end
    if (state_reg.out_cfg[srdc_pkg::OC_FORMAT_BIT]) begin
      smp[15] = ~smp[15];
    end
    state_next.sample = smp;
  end

  // Single state register; all outputs come from it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.global_gate <= srdc_pkg::RST_GLOBAL_GATE;
      state_reg.block_gates <= srdc_pkg::RST_BLOCK_GATES;
      state_reg.out_cfg <= srdc_pkg::RST_OUT_CFG;
      state_reg.src_sel <= srdc_pkg::RST_SRC_SEL;
      state_reg.osc_mode <= srdc_pkg::RST_OSC_MODE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output mapping straight from flops
  assign reg_rdata = state_reg.rdata;
  assign sync_pattern = state_reg.sync[srdc_pkg::GI_GLOBAL];
  assign sync_serial = state_reg.sync[srdc_pkg::GI_SERIAL];
  assign sync_filter = state_reg.sync[srdc_pkg::GI_FILTER];
  assign sync_osc = state_reg.sync[srdc_pkg::GI_OSC];
  assign sync_timer = state_reg.sync[srdc_pkg::GI_TIMER];
  assign filter_in = state_reg.filt;
  assign sample_out = state_reg.sample;
  assign gain_6db = state_reg.gain;
  assign complex_decimation_enable = state_reg.out_cfg[srdc_pkg::OC_COMPLEX_BIT];
  assign output_width_select = state_reg.out_cfg[srdc_pkg::OC_WIDTH_BIT];
  assign offset_binary = state_reg.out_cfg[srdc_pkg::OC_FORMAT_BIT];
  assign osc_load = state_reg.load;
  assign negative_image_select = state_reg.osc_mode[srdc_pkg::OM_NEG_IMAGE_BIT];
  assign osc_coherent_mode = state_reg.osc_mode[srdc_pkg::OM_MODE_BIT];
endmodule
